// [logic/dcbm_fifo.sv]
// deep dual-port bus-matching fifo with programmable flags, single system clock
//
// Decided for this implementation: the address map and the Wishbone register port.
`default_nettype none
// Contract
// R1: depth 65536 or 131072 words of 36
// R2: port widths latched from straps at reset
// R3: clocked write stores on write-clock edge
// R4: strobe write stores on strobe rise
// R5: clocked read delivers on read-clock edge
// R6: strobe read delivers on strobe rise
// R7: strobe read forces standard mode, oe tristate
// R8: write and read clocks fully independent
// R9: standard mode needs read for first word
// R10: fall-through shows first word after three edges
// R11: later words need read enable low
// R12: serial-in pin picks timing mode
// R13: dual flags: empty/full or ready pair
// R14: independent almost-empty and almost-full offsets
// R15: selects and load pick default offsets
// R16: serial load shifts serial-in on write edge
// R17: parallel load takes offsets from data
// R18: read with load shows offsets on outputs
// R19: master reset clears pointers, latches mode
// R20: partial reset keeps mode and offsets
// R21: almost flags asynchronous or synchronous timing
// R22: fall-through output chains to next input
// R23: synchronous almost flags update on own clock
// R24: big-endian gives most significant piece first
// R25: half-full shows count above half
// R26: writes when full, reads when empty ignored
module dcbm_fifo #(
   parameter int DEPTH = dcbm_pkg::DCBM_DEPTH_SMALL
) (
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        full_reset_n_i,
   input  wire logic        pointer_reset_n_i,
   input  wire logic        in_width_sel_i,
   input  wire logic        out_width_sel_i,
   input  wire logic        width_match_sel_i,
   input  wire logic        byte_order_sel_i,
   input  wire logic        flag_timing_sel_i,
   input  wire logic        wr_async_sel_i,
   input  wire logic        rd_async_sel_i,
   input  wire logic        offset_default_sel0_i,
   input  wire logic        offset_default_sel1_i,
   input  wire logic        offset_load_n_i,
   input  wire logic        serial_load_en_n_i,
   input  wire logic        fallthru_sel_serial_in_i,
   input  wire logic        wclk_i,
   input  wire logic        wr_strobe_i,
   input  wire logic        wr_en_n_i,
   input  wire logic [35:0] data_in_i,
   input  wire logic        rclk_i,
   input  wire logic        rd_strobe_i,
   input  wire logic        rd_en_n_i,
   input  wire logic        out_en_n_i,
   output logic      [35:0] data_out_o,
   output logic             data_out_oe_o,
   output logic             empty_or_out_ready_o,
   output logic             full_or_in_ready_o,
   output logic             half_full_flag_o,
   output logic             almost_empty_flag_o,
   output logic             almost_full_flag_o
);
   import dcbm_pkg::*;

   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;
   localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
   localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);

   typedef struct packed {
      logic                  wclk_q;
      logic                  rclk_q;
      logic                  wstb_q;
      logic                  rstb_q;
      dcbm_width_e           in_w;
      dcbm_width_e           out_w;
      logic                  fall_through_mode;
      logic                  big_end;
      logic                  serial_mode;
      logic                  sync_flags;
      logic                  wr_async;
      logic                  rd_async;
      logic [AW-1:0]         wr_ptr;
      logic [AW-1:0]         rd_ptr;
      logic [CW-1:0]         count;
      logic [35:0]           wacc;
      logic [1:0]            wpc;
      logic [1:0]            rpc;
      logic [35:0]           out_word;
      logic                  out_valid;
      logic [1:0]            ft_cnt;
      logic [DCBM_OFF_W-1:0] ae_off;
      logic [DCBM_OFF_W-1:0] af_off;
      logic                  par_wsel;
      logic                  par_rsel;
      logic                  soft_prs;
      logic [35:0]           dout;
      logic                  oe;
      logic                  ef;
      logic                  ff;
      logic                  hf;
      logic                  almost_empty_flag;
      logic                  almost_full_flag;
      logic                  ack;
      logic [31:0]           dat_o;
   } dcbm_state_s;

   dcbm_state_s st;
   dcbm_state_s next_st;
   logic [35:0] mem [DEPTH];

   function automatic logic [1:0] dcbm_last(input dcbm_width_e w);
      case (w)
         DCBM_W18: dcbm_last = 2'h1;
         DCBM_W9:  dcbm_last = 2'h3;
         default:  dcbm_last = 2'h0;
      endcase
   endfunction

   // big-endian walks lanes from the top down
   function automatic logic [35:0] dcbm_get(input logic [35:0] word, input logic [1:0] idx,
                                            input dcbm_width_e w, input logic big);
      logic [1:0] lane;
      lane = big ? 2'(dcbm_last(w) - idx) : idx;
      case (w)
         DCBM_W18: dcbm_get = {18'h0_0000, word[DCBM_HALF_W*int'(lane) +: DCBM_HALF_W]};
         DCBM_W9:  dcbm_get = {27'h000_0000, word[DCBM_BYTE_W*int'(lane) +: DCBM_BYTE_W]};
         default:  dcbm_get = word;
      endcase
   endfunction

   function automatic logic [35:0] dcbm_put(input logic [35:0] acc, input logic [35:0] d,
                                            input logic [1:0] idx, input dcbm_width_e w,
                                            input logic big);
      logic [1:0]  lane;
      logic [35:0] r;
      lane = big ? 2'(dcbm_last(w) - idx) : idx;
      r = acc;
      case (w)
         DCBM_W18: r[DCBM_HALF_W*int'(lane) +: DCBM_HALF_W] = d[DCBM_HALF_W-1:0];
         DCBM_W9:  r[DCBM_BYTE_W*int'(lane) +: DCBM_BYTE_W] = d[DCBM_BYTE_W-1:0];
         default:  r = d;
      endcase
      dcbm_put = r;
   endfunction

   // pin edges are seen through one sample; pins are taken as synchronous
   logic          w_rise;
   logic          r_rise;
   logic          data_wr;
   logic          wr_accept;
   logic          wr_word;
   logic          par_ld;
   logic          ser_ld;
   logic          rd_req;
   logic          off_rd;
   logic          rd_adv;
   logic          rd_load;
   logic          rd_drop;
   logic          is_full;
   logic [AW-1:0] wr_addr;
   logic [2:0]    def_idx;

   always_comb begin
      w_rise  = wclk_i & ~st.wclk_q;
      r_rise  = rclk_i & ~st.rclk_q;
      is_full = (st.count == FULL_CNT);
      // strobe mode ignores enable, the far side ties it low
      data_wr = st.wr_async ? (wr_strobe_i & ~st.wstb_q)                           // R4
                            : (w_rise & ~wr_en_n_i & offset_load_n_i);           // R3
      wr_accept = data_wr & ~is_full;                                            // R26
      wr_word   = wr_accept & (st.wpc == dcbm_last(st.in_w));
      par_ld  = ~st.wr_async & w_rise & ~wr_en_n_i & ~offset_load_n_i & ~st.serial_mode; // R17
      ser_ld  = w_rise & ~serial_load_en_n_i & ~offset_load_n_i & st.serial_mode;      // R16
      rd_req  = st.rd_async ? (rd_strobe_i & ~st.rstb_q)                         // R6
                            : (r_rise & ~rd_en_n_i & offset_load_n_i);           // R5
      off_rd  = ~st.rd_async & r_rise & ~rd_en_n_i & ~offset_load_n_i;           // R18
      rd_adv  = rd_req & st.out_valid & (st.rpc != dcbm_last(st.out_w));         // R24
      if (st.fall_through_mode) begin
         rd_load = (st.out_valid & rd_req & ~rd_adv & (st.count != '0))          // R11
                 | (~st.out_valid & (st.count != '0) & r_rise & (st.ft_cnt == 2'h2)); // R10
         rd_drop = st.out_valid & rd_req & ~rd_adv & (st.count == '0);
      end else begin
         rd_load = rd_req & ~rd_adv & (st.count != '0);                          // R9 R26
         rd_drop = 1'b0;
      end
      wr_addr = st.wr_ptr;
      def_idx = {offset_load_n_i, offset_default_sel1_i, offset_default_sel0_i};
   end

   always_comb begin
      next_st        = st;
      next_st.wclk_q = wclk_i;
      next_st.rclk_q = rclk_i;
      next_st.wstb_q = wr_strobe_i;
      next_st.rstb_q = rd_strobe_i;
      next_st.soft_prs = 1'b0;

      // write side: narrow pieces gather into one stored word
      if (wr_accept) begin
         next_st.wacc = dcbm_put(st.wacc, data_in_i, st.wpc, st.in_w, st.big_end); // R24
         next_st.wpc  = wr_word ? 2'h0 : 2'(st.wpc + 2'h1);
      end
      if (wr_word) begin
         next_st.wr_ptr = AW'(st.wr_ptr + 1'b1);
      end

      // offsets: parallel loads alternate almost-empty then almost-full
      if (par_ld) begin
         if (st.par_wsel) next_st.af_off = data_in_i[DCBM_OFF_W-1:0];             // R14
         else next_st.ae_off = data_in_i[DCBM_OFF_W-1:0];
         next_st.par_wsel = ~st.par_wsel;
      end
      if (ser_ld) begin
         {next_st.af_off, next_st.ae_off} = {fallthru_sel_serial_in_i,
                                             st.af_off, st.ae_off[DCBM_OFF_W-1:1]};
      end

      // read side
      if (st.fall_through_mode && !st.out_valid && st.count != '0 && r_rise && st.ft_cnt != 2'h2) begin
         next_st.ft_cnt = 2'(st.ft_cnt + 2'h1);
      end
      if (rd_adv) begin
         next_st.rpc  = 2'(st.rpc + 2'h1);
         next_st.dout = dcbm_get(st.out_word, next_st.rpc, st.out_w, st.big_end);
      end
      if (rd_load) begin
         next_st.out_word  = mem[st.rd_ptr];
         next_st.rd_ptr    = AW'(st.rd_ptr + 1'b1);
         next_st.out_valid = 1'b1;
         next_st.rpc       = 2'h0;
         next_st.ft_cnt    = 2'h0;
         next_st.dout = dcbm_get(mem[st.rd_ptr], 2'h0, st.out_w, st.big_end);   // R22
      end
      if (rd_drop) begin
         next_st.out_valid = 1'b0;
      end
      if (off_rd) begin
         next_st.dout     = {18'h0_0000, st.par_rsel ? st.af_off : st.ae_off};
         next_st.par_rsel = ~st.par_rsel;
      end
      next_st.count = CW'(st.count + CW'(wr_word) - CW'(rd_load));

      // flags follow the settled count one cycle later
      next_st.ef = st.fall_through_mode ? ~st.out_valid : (st.count != '0);                   // R13
      next_st.ff = st.fall_through_mode ? is_full : ~is_full;
      next_st.hf = ~(st.count > HALF_CNT);                                       // R25
      // synchronous mode ties each almost flag to its own port clock
      if (!st.sync_flags || r_rise) begin                                        // R21 R23
         next_st.almost_empty_flag = ~(st.count <= CW'(st.ae_off));                            // R14
      end
      if (!st.sync_flags || w_rise) begin                                        // R23
         next_st.almost_full_flag = ~(st.count >= CW'(FULL_CNT - CW'(st.af_off)));
      end
      next_st.oe = ~out_en_n_i;                                                  // R7

      // register bus: one wait state, ack dropped after one cycle
      next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;
      if (wb_cyc_i && wb_stb_i && !st.ack) begin
         if (wb_we_i && wb_adr_i == DCBM_ADR_CTRL && wb_sel_i[0]) begin
            next_st.soft_prs = wb_dat_i[DCBM_CTRL_PRS_BIT];
         end
         case (wb_adr_i)
            DCBM_ADR_CTRL:   next_st.dat_o = DCBM_CTRL_RESET;
            DCBM_ADR_STATUS: next_st.dat_o = {6'h00, st.almost_empty_flag, st.almost_full_flag, st.hf, st.ff, st.ef,
                                              st.out_valid, 20'(st.count)};
            DCBM_ADR_CONFIG: next_st.dat_o = {22'h00_0000, st.in_w, st.out_w, st.fall_through_mode,
                                              st.big_end, st.serial_mode, st.sync_flags,
                                              st.wr_async, st.rd_async};
            DCBM_ADR_AE_OFF: next_st.dat_o = 32'(st.ae_off);
            DCBM_ADR_AF_OFF: next_st.dat_o = 32'(st.af_off);
            default:         next_st.dat_o = DCBM_UNMAPPED;
         endcase
      end

      // partial reset: data lost, settings kept, flags recomputed next cycle
      if (!pointer_reset_n_i || st.soft_prs) begin                               // R20
         next_st.wr_ptr    = '0;
         next_st.rd_ptr    = '0;
         next_st.count     = '0;
         next_st.wpc       = 2'h0;
         next_st.rpc       = 2'h0;
         next_st.ft_cnt    = 2'h0;
         next_st.out_valid = 1'b0;
         next_st.par_wsel  = 1'b0;
         next_st.par_rsel  = 1'b0;
      end
      // master reset: straps sampled every cycle it is held
      if (!full_reset_n_i) begin                                                 // R19
         next_st.wr_ptr      = '0;
         next_st.rd_ptr      = '0;
         next_st.count       = '0;
         next_st.wpc         = 2'h0;
         next_st.rpc         = 2'h0;
         next_st.ft_cnt      = 2'h0;
         next_st.out_valid   = 1'b0;
         next_st.par_wsel    = 1'b0;
         next_st.par_rsel    = 1'b0;
         next_st.dout        = DCBM_DOUT_RESET;
         next_st.in_w = !width_match_sel_i ? DCBM_W36 : !in_width_sel_i ? DCBM_W36  // R2
                      : !out_width_sel_i ? DCBM_W18 : DCBM_W9;
         next_st.out_w = !width_match_sel_i ? DCBM_W36 : in_width_sel_i ? DCBM_W36
                       : !out_width_sel_i ? DCBM_W18 : DCBM_W9;
         // strobe reads cannot fall through
         next_st.fall_through_mode        = fallthru_sel_serial_in_i & ~rd_async_sel_i;        // R12 R7
         next_st.big_end     = ~byte_order_sel_i;
         next_st.serial_mode = offset_load_n_i;
         next_st.sync_flags  = flag_timing_sel_i;
         next_st.wr_async    = wr_async_sel_i;
         next_st.rd_async    = rd_async_sel_i;
         next_st.ae_off      = DCBM_OFF_W'(DCBM_DEF_OFF[def_idx]);               // R15
         next_st.af_off      = DCBM_OFF_W'(DCBM_DEF_OFF[def_idx]);
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st       <= '0;
         st.ef    <= 1'b0;
         st.ff    <= 1'b1;
         st.hf    <= 1'b1;
         st.almost_empty_flag   <= 1'b0;
         st.almost_full_flag   <= 1'b1;
         st.in_w  <= DCBM_W36;
         st.out_w <= DCBM_W36;
      end else begin
         st <= next_st;
      end
   end

   // storage has no reset; only pointers define contents
   always_ff @(posedge sys_clk_i) begin
      if (wr_word && full_reset_n_i && pointer_reset_n_i && !st.soft_prs) begin   // R1 R8
         mem[wr_addr] <= dcbm_put(st.wacc, data_in_i, st.wpc, st.in_w, st.big_end);
      end
   end

   assign wb_dat_o             = st.dat_o;
   assign wb_ack_o             = st.ack;
   assign data_out_o           = st.dout;
   assign data_out_oe_o        = st.oe;
   assign empty_or_out_ready_o = st.ef;
   assign full_or_in_ready_o   = st.ff;
   assign half_full_flag_o     = st.hf;
   assign almost_empty_flag_o  = st.almost_empty_flag;
   assign almost_full_flag_o   = st.almost_full_flag;

   default clocking dcbm_cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   logic quiet;
   assign quiet = full_reset_n_i & pointer_reset_n_i & ~st.soft_prs;

   a_master_ptr_clear: assert property ( // R19
      !full_reset_n_i |=> st.wr_ptr == '0 && st.rd_ptr == '0 && st.count == '0)
      else $error("pointers not cleared by master reset");
   a_partial_keeps_cfg: assert property ( // R20
      full_reset_n_i && !pointer_reset_n_i |=> st.ae_off == $past(st.ae_off)
         && st.fall_through_mode == $past(st.fall_through_mode) && st.count == '0)
      else $error("partial reset lost settings");
   a_write_counts_up: assert property ( // R3
      quiet && wr_word && !rd_load |=> st.count == CW'($past(st.count) + 1'b1))
      else $error("accepted word not counted");
   a_full_write_ignored: assert property ( // R26
      quiet && is_full && data_wr |=> st.wr_ptr == $past(st.wr_ptr))
      else $error("write taken while full");
   a_std_holds_output: assert property ( // R9
      !st.fall_through_mode && !st.out_valid && !rd_req ##0 full_reset_n_i |=> !st.out_valid)
      else $error("standard mode presented word without read");
   a_fall_through_mode_three_edges: assert property ( // R10
      st.fall_through_mode && !st.out_valid && st.ft_cnt != 2'h2 |=> !st.out_valid)
      else $error("fall-through word appeared early");
   a_empty_flag_low: assert property ( // R13
      !st.fall_through_mode && st.count == '0 && full_reset_n_i |=> !st.ef)
      else $error("empty flag not asserted");
   a_sync_pae_held: assert property ( // R23
      st.sync_flags && !r_rise && full_reset_n_i |=> $stable(st.almost_empty_flag))
      else $error("almost-empty moved without read clock");
   a_half_full_level: assert property ( // R25
      st.count > HALF_CNT |=> !st.hf)
      else $error("half-full not asserted");
   a_serial_shift_in: assert property ( // R16
      ser_ld && full_reset_n_i |=> st.af_off[DCBM_OFF_W-1] == $past(fallthru_sel_serial_in_i))
      else $error("serial bit not shifted in");
endmodule
`default_nettype wire

// [shared/dcbm_pkg.sv]
// constants and types shared by the bus-matching fifo
`default_nettype none
package dcbm_pkg;
   // port width selections latched at master reset
   typedef enum logic [1:0] {DCBM_W36, DCBM_W18, DCBM_W9} dcbm_width_e;

   localparam int          DCBM_DEPTH_SMALL = 65536;
   localparam int          DCBM_DEPTH_LARGE = 131072;
   localparam int          DCBM_DATA_W      = 36;
   localparam int          DCBM_HALF_W      = 18;
   localparam int          DCBM_BYTE_W      = 9;
   localparam int          DCBM_OFF_W       = 18;

   // eight default flag offsets chosen by {load, sel1, sel0}
   localparam logic [9:0]  DCBM_DEF_OFF [8] = '{10'h007, 10'h00F, 10'h01F, 10'h03F,
                                               10'h07F, 10'h0FF, 10'h1FF, 10'h3FF};

   // register map on the bus (byte addresses)
   localparam logic [7:0]  DCBM_ADR_CTRL    = 8'h00;
   localparam logic [7:0]  DCBM_ADR_STATUS  = 8'h04;
   localparam logic [7:0]  DCBM_ADR_CONFIG  = 8'h08;
   localparam logic [7:0]  DCBM_ADR_AE_OFF  = 8'h0C;
   localparam logic [7:0]  DCBM_ADR_AF_OFF  = 8'h10;
   localparam int          DCBM_CTRL_PRS_BIT = 0;
   localparam logic [31:0] DCBM_CTRL_RESET  = 32'h0000_0000;
   localparam logic [31:0] DCBM_UNMAPPED    = 32'h0000_0000;
   localparam logic [35:0] DCBM_DOUT_RESET  = 36'h0_0000_0000;
endpackage
`default_nettype wire

// [verif/dcbm_peer.sv]
// writer and reader logic that clocks words into and out of the fifo
`default_nettype none
module dcbm_peer (
   input  wire logic        sys_clk_i,
   input  wire logic        go_i,
   input  wire logic        wr_i,
   input  wire logic        en_i,
   input  wire logic [35:0] word_i,
   output logic             wclk_o,
   output logic             rclk_o,
   output logic             wr_en_n_o,
   output logic             rd_en_n_o,
   output logic      [35:0] data_o,
   output logic             busy_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] cnt = 3'h0;
   logic       hi;
   // clock high two cycles, low at least three: the fifo needs a low sample between edges
   always_ff @(posedge sys_clk_i) begin
      if (go_i) begin
         cnt <= 3'h4;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
      end
   end
   assign hi        = cnt >= 3'h3;
   assign busy_o    = cnt != 3'h0;
   assign wclk_o    = hi && wr_i;
   assign rclk_o    = hi && !wr_i;
   assign wr_en_n_o = !(hi && wr_i && en_i);
   assign rd_en_n_o = !(hi && !wr_i && en_i);
   // released bus carries the inverse, so a stale word never passes for a fresh one
   assign data_o    = (hi && wr_i) ? word_i : ~word_i;
endmodule
`default_nettype wire

// [verif/test_dual_clock_bus_matching_fifo.sv]
// self-checking bench: bus-matching fifo with a writer/reader model and a bus master
`default_nettype none
module test_dual_clock_bus_matching_fifo;
   timeunit 1ns;
   timeprecision 1ps;
   import dcbm_pkg::*;
   localparam int DEPTH = 16;
   logic        sys_clk_i = 1'b0, nrst_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic        wb_ack_o, full_reset_n_i = 1'b1, pointer_reset_n_i = 1'b1, out_en_n_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        in_width_sel_i = 1'b0, out_width_sel_i = 1'b0, width_match_sel_i = 1'b0;
   logic        byte_order_sel_i = 1'b0, flag_timing_sel_i = 1'b0, offset_load_n_i = 1'b1;
   logic        offset_default_sel0_i = 1'b0, offset_default_sel1_i = 1'b0;
   logic        fallthru_sel_serial_in_i = 1'b0, serial_load_en_n_i = 1'b1, rd_async_sel_i = 1'b0;
   // strobe ports idle: traffic goes through the clocked ports except in s_strobe, which pulses both strobes
   logic        wr_strobe_i = 1'b0, rd_strobe_i = 1'b0, wr_async_sel_i = 1'b0;
   logic        wclk_i, rclk_i, wr_en_n_i, rd_en_n_i, data_out_oe_o, empty_or_out_ready_o;
   logic        full_or_in_ready_o, half_full_flag_o, almost_empty_flag_o, almost_full_flag_o;
   logic [35:0] data_in_i, data_out_o, word = 36'h0;
   logic        go = 1'b0, wr = 1'b0, en = 1'b0, busy;
   int          miscompares = 0, comparisons = 0, cycles = 0;
   dcbm_fifo #(.DEPTH(DEPTH)) uut (.*);
   dcbm_peer peer (.sys_clk_i(sys_clk_i), .go_i(go), .wr_i(wr), .en_i(en), .word_i(word),
      .wclk_o(wclk_i), .rclk_o(rclk_i), .wr_en_n_o(wr_en_n_i), .rd_en_n_o(rd_en_n_i),
      .data_o(data_in_i), .busy_o(busy));
   initial forever #4 sys_clk_i = ~sys_clk_i;
   task automatic finish_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         miscompares++;
         finish_test();
      end
   end
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      @(posedge sys_clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
      do @(posedge sys_clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                          input string what);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      chk(what, {4'h0, e}, {4'h0, q & m});
   endtask
   // one port transfer; flags settle two cycles after the edge
   task automatic op(input logic w, input logic e, input logic [35:0] d);
      @(posedge sys_clk_i);
      {go, wr, en, word} <= {1'b1, w, e, d};
      @(posedge sys_clk_i);
      go <= 1'b0;
      @(posedge sys_clk_i);
      while (busy) @(posedge sys_clk_i);
      repeat (3) @(posedge sys_clk_i);
   endtask
   // straps {ld, bm, iw, ow, be, ft, sel1, sel0}, load strap low picks parallel loading
   task automatic mrst(input logic [7:0] s);
      @(posedge sys_clk_i);
      {width_match_sel_i, in_width_sel_i, out_width_sel_i, byte_order_sel_i} <= s[6:3];
      {fallthru_sel_serial_in_i, offset_default_sel1_i, offset_default_sel0_i} <= s[2:0];
      {flag_timing_sel_i, offset_load_n_i, full_reset_n_i} <= {s[2], s[7], 1'b0};
      repeat (3) @(posedge sys_clk_i);
      {offset_load_n_i, full_reset_n_i} <= 2'b11;
      repeat (2) @(posedge sys_clk_i);
   endtask
   task automatic s_std;
      reg_chk(DCBM_ADR_AE_OFF, 32'h3_FFFF, 32'(DCBM_DEF_OFF[0]), "ae default");
      reg_chk(DCBM_ADR_AF_OFF, 32'h3_FFFF, 32'(DCBM_DEF_OFF[0]), "af default");
      reg_chk(8'h40, 32'hFFFF_FFFF, DCBM_UNMAPPED, "unmapped read");
      chk("empty flag", 36'h0, 36'(empty_or_out_ready_o));
      op(1'b1, 1'b1, 36'h9_A5A5_1234);
      op(1'b1, 1'b1, 36'h6_0F0F_8765);
      chk("output before read", DCBM_DOUT_RESET, data_out_o);
      chk("empty flag", 36'h1, 36'(empty_or_out_ready_o));
      op(1'b0, 1'b1, 36'h0);
      chk("first word", 36'h9_A5A5_1234, data_out_o);
      repeat (2) op(1'b0, 1'b1, 36'h0);
      chk("read on empty", 36'h6_0F0F_8765, data_out_o);
   endtask
   task automatic s_full;
      logic [31:0] q;
      for (int i = 0; i <= DEPTH; i++) begin
         op(1'b1, 1'b1, 36'(i + 16));
      end
      reg_chk(DCBM_ADR_STATUS, 32'h000F_FFFF, 32'(DEPTH), "stored count");
      chk("full flag", 36'h0, 36'(full_or_in_ready_o));
      chk("half full", 36'h0, 36'(half_full_flag_o));
      chk("almost full", 36'h0, 36'(almost_full_flag_o));
      chk("almost empty", 36'h1, 36'(almost_empty_flag_o));
      op(1'b0, 1'b1, 36'h0);
      chk("oldest word", 36'h10, data_out_o);
      wb(1'b1, DCBM_ADR_CTRL, 32'h1, q);
      repeat (3) @(posedge sys_clk_i);
      reg_chk(DCBM_ADR_STATUS, 32'h000F_FFFF, 32'h0, "count after reset");
   endtask
   task automatic s_offs;
      offset_load_n_i <= 1'b0;
      op(1'b1, 1'b1, 36'h5);
      op(1'b1, 1'b1, 36'hA);
      op(1'b0, 1'b1, 36'h0);
      chk("offset readback", 36'h5, data_out_o);
      offset_load_n_i <= 1'b1;
      pointer_reset_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      pointer_reset_n_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      reg_chk(DCBM_ADR_AE_OFF, 32'h3_FFFF, 32'h5, "ae kept");
      reg_chk(DCBM_ADR_AF_OFF, 32'h3_FFFF, 32'hA, "af kept");
   endtask
   task automatic s_fall_through_mode;
      mrst(8'h05);
      reg_chk(DCBM_ADR_CONFIG, 32'h20, 32'h20, "fall-through mode");
      op(1'b1, 1'b1, 36'h3_C3C3_5A5A);
      repeat (2) op(1'b0, 1'b0, 36'h0);
      chk("ready too early", 36'h1, 36'(empty_or_out_ready_o));
      op(1'b0, 1'b0, 36'h0);
      chk("fall-through word", 36'h3_C3C3_5A5A, data_out_o);
      chk("output ready", 36'h0, 36'(empty_or_out_ready_o));
      op(1'b1, 1'b1, 36'h1_2345_6789);
      op(1'b0, 1'b0, 36'h0);
      chk("held without enable", 36'h3_C3C3_5A5A, data_out_o);
      out_en_n_i <= 1'b1;
      op(1'b0, 1'b1, 36'h0);
      chk("advanced word", 36'h1_2345_6789, data_out_o);
      chk("output disabled", 36'h0, 36'(data_out_oe_o));
   endtask
   task automatic s_match;
      logic [35:0] w;
      w = 36'hA_BCDE_F012;
      for (int be = 0; be < 2; be++) begin
         mrst({4'b0100, 1'(be), 3'b000});
         op(1'b1, 1'b1, w);
         op(1'b0, 1'b1, 36'h0);
         chk("first piece", be ? 36'(w[17:0]) : 36'(w[35:18]), data_out_o);
         op(1'b0, 1'b1, 36'h0);
         chk("second piece", be ? 36'(w[35:18]) : 36'(w[17:0]), data_out_o);
      end
   endtask
   // serial-in bit i lands in bit i of {af, ae} after 36 shifts
   task automatic s_serial;
      logic [35:0] v;
      v = {18'h0_000C, 18'h0_0003};
      mrst(8'h80);
      reg_chk(DCBM_ADR_AE_OFF, 32'h3_FFFF, 32'(DCBM_DEF_OFF[4]), "serial default");
      {offset_load_n_i, serial_load_en_n_i} <= 2'b00;
      for (int i = 0; i < 36; i++) begin
         fallthru_sel_serial_in_i <= v[i];
         op(1'b1, 1'b0, 36'h0);
      end
      {offset_load_n_i, serial_load_en_n_i} <= 2'b11;
      reg_chk(DCBM_ADR_AE_OFF, 32'h3_FFFF, 32'h3, "serial ae");
      reg_chk(DCBM_ADR_AF_OFF, 32'h3_FFFF, 32'hC, "serial af");
   endtask
   // idle writer model shows the inverse of word on the data pins
   task automatic s_strobe;
      {wr_async_sel_i, rd_async_sel_i, word} <= {2'b11, 36'h5_5AA5_A55A};
      mrst(8'h04);
      reg_chk(DCBM_ADR_CONFIG, 32'h23, 32'h3, "strobe forces standard");
      wr_strobe_i <= 1'b1;
      @(posedge sys_clk_i);
      {wr_strobe_i, rd_strobe_i} <= 2'b01;
      @(posedge sys_clk_i);
      rd_strobe_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      chk("strobe word", 36'hA_A55A_5AA5, data_out_o);
      {wr_async_sel_i, rd_async_sel_i} <= 2'b00;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      mrst(8'h00);
      s_std();
      s_full();
      s_offs();
      s_fall_through_mode();
      s_match();
      s_serial();
      s_strobe();
      finish_test();
   end
endmodule
`default_nettype wire
